// ---- shared/csp_consts.vh ----
// Constants for the clock source select and PLL rate block.
//
// Contract
// R1: A two-bit source select picks the selected oscillator clock: 01 internal, 10 RC, 11 crystal, 00 unused.
// R2: The oscillator output pin carries the bus frequency for internal or RC and the inverted crystal for crystal.
// R3: The internal oscillator runs freely after every reset, whatever source is selected.
// R4: The internal oscillator stops in stop mode only when the stop-mode disable bit is set.
// R5: Two bits of system_config_two choose the tick reference: 00 internal, 01 RC, 10 crystal, 11 unused.
// R6: RC or crystal feeds the tick reference only when it is also the selected source; internal always does.
// R7: The VCO rate is 2^P times the divided PLL clock, which is four times the bus rate, with P from 0 to 3.
// R8: The VCO rate equals the reference rate times 2^P times N divided by R, with N from 1 to 4095.
// R9: The PLL compares phase at the reference rate divided by R.
// R10: The bus clock runs at half the clock module output, taken from the PLL or the selected oscillator.
// R11: Select bits are copied from the register only at a safe boundary so clocks switch without glitches.
`ifndef CSP_CONSTS_VH
`define CSP_CONSTS_VH

// Register indices; byte address is four times the index.
`define CSP_IDX_SYSTEM_CONFIG_TWO     6'h1D
`define CSP_IDX_PLL_CTRL    6'h1E
`define CSP_IDX_PLL_MULT    6'h1F
`define CSP_IDX_PLL_REFDIV  6'h20
`define CSP_IDX_STATUS      6'h21

// Field positions in system_config_two.
`define CSP_CFG_STOP_DIS    0
`define CSP_CFG_TICK_LO     1
`define CSP_CFG_TICK_HI     2
`define CSP_CFG_OSC_LO      3
`define CSP_CFG_OSC_HI      4

// Field positions in the PLL control register.
`define CSP_PLL_P_LO        0
`define CSP_PLL_P_HI        1
`define CSP_PLL_ON          2

// Source and tick reference encodings.
`define CSP_OSC_NONE        2'h0
`define CSP_OSC_INT         2'h1
`define CSP_OSC_RC          2'h2
`define CSP_OSC_XTAL        2'h3
`define CSP_TICK_INT        2'h0
`define CSP_TICK_RC         2'h1
`define CSP_TICK_XTAL       2'h2

// Reset values.
`define CSP_RST_SYSTEM_CONFIG_TWO     8'h08
`define CSP_RST_PLL_CTRL    3'h0
`define CSP_RST_PLL_MULT    12'h001
`define CSP_RST_PLL_REFDIV  12'h001

// Internal oscillator divide from the 40 MHz system clock.
`define CSP_CLK_HZ          40000000
`define CSP_INTERNAL_OSC_CLOCK_HZ         4000000
`define CSP_INTERNAL_OSC_CLOCK_DIV        12'h00A

`endif

// ---- logic/csp_pulse_div.v ----
// Pulse divider: one output pulse for every div_i input pulses.
`timescale 1ns/1ps
module csp_pulse_div (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        run_i,
    input  wire        tick_i,
    input  wire [11:0] div_i,
    output reg         tick_o
);
    reg [11:0] count_reg;
    wire       last_w;

    // A divide of zero behaves as one.
    assign last_w = (div_i == 12'h000) || (count_reg >= div_i - 12'h001);

    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            count_reg <= 12'h000;
            tick_o    <= 1'b0;
        end else begin
            tick_o <= tick_i && last_w;
            if (tick_i) begin
                count_reg <= last_w ? 12'h000 : count_reg + 12'h001;
            end
        end
    end
endmodule

// ---- logic/csp_rate_synth.v ----
// Fractional rate synthesiser: out rate is ref rate times mult_i over div_i.
`timescale 1ns/1ps
module csp_rate_synth (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        run_i,
    input  wire        ref_tick_i,
    input  wire [14:0] mult_i,
    input  wire [11:0] div_i,
    output reg         tick_o
);
    reg  [19:0] acc_reg;
    wire [19:0] den_w;
    wire        fire_w;
    wire [19:0] acc_next;

    assign den_w    = (div_i == 12'h000) ? 20'h00001 : {8'h00, div_i};
    assign fire_w   = acc_reg >= den_w;
    // Each reference edge adds mult; each output edge spends one divide.
    assign acc_next = acc_reg + (ref_tick_i ? {5'h00, mult_i} : 20'h00000)
                      - (fire_w ? den_w : 20'h00000);

    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            acc_reg <= 20'h00000;
            tick_o  <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_o  <= fire_w;
        end
    end
endmodule

// ---- logic/csp_clock_select.v ----
// Clock source selection, tick reference selection and PLL rate model.
`timescale 1ns/1ps
`include "csp_consts.vh"
module csp_clock_select (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave.
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Oscillator waveforms and mode.
    input  wire        rc_osc_level_i,
    input  wire        xtal_osc_level_i,
    input  wire        stop_mode_i,
    // Clock enables and pin.
    output wire        internal_osc_clock_o,
    output reg         selected_osc_clock_o,
    output reg         tick_reference_clock_o,
    output wire        vco_clock_o,
    output wire        pll_divided_clock_o,
    output wire        pll_compare_o,
    output reg         clock_module_output_o,
    output wire        bus_clock_o,
    output reg         osc_output_pin_o
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    reg  [7:0]  config_two_reg;
    reg  [2:0]  pll_ctrl_reg;
    reg  [11:0] pll_mult_reg;
    reg  [11:0] pll_refdiv_reg;
    reg  [1:0]  osc_sel_reg;
    reg  [1:0]  tick_sel_reg;
    reg         apply_pending_reg;
    reg         rc_prev_reg;
    reg         xtal_prev_reg;
    reg  [31:0] read_next;

    wire        bus_req_w;
    wire        wr_w;
    wire [5:0]  index_w;
    wire        internal_osc_clock_run_w;
    wire        internal_osc_clock_tick_w;
    wire        rc_tick_w;
    wire        xtal_tick_w;
    wire        osc_tick_w;
    wire        ref_tick_w;
    wire        pll_on_w;
    wire [1:0]  p_w;
    wire [14:0] vco_mult_w;
    wire [11:0] p_div_w;
    wire        cgm_tick_w;

    localparam [7:0] cfg_reset_val = `CSP_RST_SYSTEM_CONFIG_TWO;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Shared decode.

    // Returns the enable of the source named by a code, or zero for unused codes.
    function pick_src;
        input [1:0] code;
        input       code_is_tick;
        input       int_t;
        input       rc_t;
        input       xtal_t;
        reg   [1:0] norm;
        begin
            norm = code;
            if (code_is_tick) begin
                norm = (code == `CSP_TICK_INT)  ? `CSP_OSC_INT  :
                       (code == `CSP_TICK_RC)   ? `CSP_OSC_RC   :
                       (code == `CSP_TICK_XTAL) ? `CSP_OSC_XTAL : `CSP_OSC_NONE;
            end
            case (norm)
                `CSP_OSC_INT:  pick_src = int_t;
                `CSP_OSC_RC:   pick_src = rc_t;
                `CSP_OSC_XTAL: pick_src = xtal_t;
                default:       pick_src = 1'b0;
            endcase
        end
    endfunction

    // Returns a power of two, 2^p, for p from 0 to 3.
    function [11:0] pow2;
        input [1:0] p;
        begin
            pow2 = 12'h001 << p;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait cycle, ack for one cycle, unmapped reads return zero.

    assign bus_req_w = cyc_i && stb_i && !ack_o;
    // Writes land at the edge where the master sees ack high, while it still holds the request.
    assign wr_w      = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign index_w   = adr_i[7:2];

    always @* begin
        read_next = 32'h00000000;
        case (index_w)
            `CSP_IDX_SYSTEM_CONFIG_TWO:    read_next = {24'h000000, config_two_reg};
            `CSP_IDX_PLL_CTRL:   read_next = {29'h00000000, pll_ctrl_reg};
            `CSP_IDX_PLL_MULT:   read_next = {20'h00000, pll_mult_reg};
            `CSP_IDX_PLL_REFDIV: read_next = {20'h00000, pll_refdiv_reg};
            `CSP_IDX_STATUS:     read_next = {26'h0000000, apply_pending_reg,
                                              !internal_osc_clock_run_w, tick_sel_reg, osc_sel_reg};
            default:             read_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req_w;
            if (bus_req_w && !we_i) begin
                dat_o <= read_next;
            end
        end
    end

    // Byte lane 0 gates every register write; the PLL multiplier and divider also need lane 1; lanes 2 and 3 are ignored.
    always @(posedge clk_i) begin
        if (rst_i) begin
            config_two_reg <= `CSP_RST_SYSTEM_CONFIG_TWO;
            pll_ctrl_reg   <= `CSP_RST_PLL_CTRL;
            pll_mult_reg   <= `CSP_RST_PLL_MULT;
            pll_refdiv_reg <= `CSP_RST_PLL_REFDIV;
        end else if (wr_w) begin
            case (index_w)
                `CSP_IDX_SYSTEM_CONFIG_TWO:    config_two_reg <= dat_i[7:0];
                `CSP_IDX_PLL_CTRL:   pll_ctrl_reg   <= dat_i[2:0];
                `CSP_IDX_PLL_MULT: begin
                    // R8 multiplier range
                    if (sel_i[1]) begin
                        pll_mult_reg <= (dat_i[11:0] == 12'h000) ? 12'h001 : dat_i[11:0];
                    end
                end
                `CSP_IDX_PLL_REFDIV: begin
                    if (sel_i[1]) begin
                        pll_refdiv_reg <= (dat_i[11:0] == 12'h000) ? 12'h001 : dat_i[11:0];
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Active select bits.

    // R11 safe switch point
    always @(posedge clk_i) begin
        if (rst_i) begin
            osc_sel_reg       <= cfg_reset_val[`CSP_CFG_OSC_HI:`CSP_CFG_OSC_LO];
            tick_sel_reg      <= cfg_reset_val[`CSP_CFG_TICK_HI:`CSP_CFG_TICK_LO];
            apply_pending_reg <= 1'b0;
        end else if (wr_w && index_w == `CSP_IDX_SYSTEM_CONFIG_TWO) begin
            apply_pending_reg <= 1'b1;
        end else if (apply_pending_reg && (internal_osc_clock_tick_w || !internal_osc_clock_run_w)) begin
            osc_sel_reg       <= config_two_reg[`CSP_CFG_OSC_HI:`CSP_CFG_OSC_LO];
            tick_sel_reg      <= config_two_reg[`CSP_CFG_TICK_HI:`CSP_CFG_TICK_LO];
            apply_pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Oscillator sources.

    // R3 free-running oscillator
    // R4 stop-mode disable
    assign internal_osc_clock_run_w = !(stop_mode_i && config_two_reg[`CSP_CFG_STOP_DIS]);

    csp_pulse_div u_internal_osc_clock_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (internal_osc_clock_run_w),
        .tick_i (1'b1),
        .div_i  (`CSP_INTERNAL_OSC_CLOCK_DIV),
        .tick_o (internal_osc_clock_tick_w)
    );

    assign internal_osc_clock_o = internal_osc_clock_tick_w;

    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_prev_reg   <= 1'b0;
            xtal_prev_reg <= 1'b0;
        end else begin
            rc_prev_reg   <= rc_osc_level_i;
            xtal_prev_reg <= xtal_osc_level_i;
        end
    end

    // R6 external oscillators live only when selected
    assign rc_tick_w   = rc_osc_level_i && !rc_prev_reg && (osc_sel_reg == `CSP_OSC_RC);
    assign xtal_tick_w = xtal_osc_level_i && !xtal_prev_reg && (osc_sel_reg == `CSP_OSC_XTAL);

    // R1 source mux
    assign osc_tick_w = pick_src(osc_sel_reg, 1'b0, internal_osc_clock_tick_w, rc_tick_w, xtal_tick_w);

    always @(posedge clk_i) begin
        if (rst_i) begin
            selected_osc_clock_o   <= 1'b0;
            tick_reference_clock_o <= 1'b0;
        end else begin
            selected_osc_clock_o   <= osc_tick_w;
            // R5 tick reference mux
            tick_reference_clock_o <= pick_src(tick_sel_reg, 1'b1, internal_osc_clock_tick_w,
                                               rc_tick_w, xtal_tick_w);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // PLL rate model.

    assign pll_on_w   = pll_ctrl_reg[`CSP_PLL_ON];
    assign p_w        = pll_ctrl_reg[`CSP_PLL_P_HI:`CSP_PLL_P_LO];
    assign ref_tick_w = selected_osc_clock_o;

    // R8 VCO rate is ref times 2^P times N over R
    assign vco_mult_w = {3'h0, pll_mult_reg} << p_w;

    csp_rate_synth u_vco (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .run_i      (pll_on_w),
        .ref_tick_i (ref_tick_w),
        .mult_i     (vco_mult_w),
        .div_i      (pll_refdiv_reg),
        .tick_o     (vco_clock_o)
    );

    // R9 phase compare at ref over R
    csp_pulse_div u_cmp_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (pll_on_w),
        .tick_i (ref_tick_w),
        .div_i  (pll_refdiv_reg),
        .tick_o (pll_compare_o)
    );

    // R7 divided PLL clock is VCO over 2^P
    assign p_div_w = pow2(p_w);

    csp_pulse_div u_p_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (pll_on_w),
        .tick_i (vco_clock_o),
        .div_i  (p_div_w),
        .tick_o (pll_divided_clock_o)
    );

    // R7 PLL path halves the divided clock so bus is a quarter of it
    csp_pulse_div u_pclk_half (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (pll_on_w),
        .tick_i (pll_divided_clock_o),
        .div_i  (pow2(2'h1)),
        .tick_o (cgm_tick_w)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Clock module output, bus clock and pin.

    always @(posedge clk_i) begin
        if (rst_i) begin
            clock_module_output_o <= 1'b0;
        end else begin
            clock_module_output_o <= pll_on_w ? cgm_tick_w : selected_osc_clock_o;
        end
    end

    // R10 bus clock is half the module output
    csp_pulse_div u_bus_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (1'b1),
        .tick_i (clock_module_output_o),
        .div_i  (pow2(2'h1)),
        .tick_o (bus_clock_o)
    );

    // R2 for internal or RC the pin toggles every module output edge, a square wave at bus rate; for crystal it is the inverted crystal
    always @(posedge clk_i) begin
        if (rst_i) begin
            osc_output_pin_o <= 1'b0;
        end else if (osc_sel_reg == `CSP_OSC_XTAL) begin
            osc_output_pin_o <= !xtal_osc_level_i;
        end else if (clock_module_output_o) begin
            osc_output_pin_o <= !osc_output_pin_o;
        end
    end

endmodule

// ---- tb/csp_clock_select_monitor.sv ----
// Assertion checker bound to the clock source select block.
`timescale 1ns/1ps
`include "csp_consts.vh"
module csp_clock_select_monitor (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    input wire        stop_mode_i,
    input wire        xtal_osc_level_i,
    input wire        internal_osc_clock_o,
    input wire        selected_osc_clock_o,
    input wire        tick_reference_clock_o,
    input wire        vco_clock_o,
    input wire        clock_module_output_o,
    input wire        bus_clock_o,
    input wire        osc_output_pin_o
);
    logic [7:0] cfg_reg;
    logic [3:0] quiet_reg;
    logic [1:0] gap_reg;
    logic       seen_reg;
    wire        settled = quiet_reg == 4'hF;
    wire [1:0]  osc     = cfg_reg[4:3];
    wire [1:0]  tck     = cfg_reg[2:1];
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the config register, cycles since its last write, output pairs.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg   <= `CSP_RST_SYSTEM_CONFIG_TWO;
            quiet_reg <= 4'h0;
            gap_reg   <= 2'h0;
            seen_reg  <= 1'b0;
        end else begin
            if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i[7:2] == `CSP_IDX_SYSTEM_CONFIG_TWO) begin
                cfg_reg   <= dat_i[7:0];
                quiet_reg <= 4'h0;
            end else if (!settled) begin
                quiet_reg <= quiet_reg + 4'h1;
            end
            if (bus_clock_o) begin
                gap_reg  <= {1'b0, clock_module_output_o};
                seen_reg <= 1'b1;
            end else if (clock_module_output_o) begin
                gap_reg <= gap_reg + 2'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_internal_osc_clock_gap; internal_osc_clock_o |=> !internal_osc_clock_o [*8]; endproperty
    a_internal_osc_clock_gap: assert property (p_internal_osc_clock_gap) else $error("internal pulse early");
    property p_internal_osc_clock_runs;
        internal_osc_clock_o ##1 (!stop_mode_i || !cfg_reg[0]) [*8] |=> ##[0:1] internal_osc_clock_o;
    endproperty
    a_internal_osc_clock_runs: assert property (p_internal_osc_clock_runs) else $error("internal osc stalled");
    property p_sel_int; settled && osc == 2'h1 |-> selected_osc_clock_o == $past(internal_osc_clock_o); endproperty
    a_sel_int: assert property (p_sel_int) else $error("selected not internal");
    property p_sel_none; settled && osc == 2'h0 |-> !selected_osc_clock_o; endproperty
    a_sel_none: assert property (p_sel_none) else $error("pulse on unused select");
    property p_pin_xtal; settled && osc == 2'h3 |-> osc_output_pin_o == !$past(xtal_osc_level_i); endproperty
    a_pin_xtal: assert property (p_pin_xtal) else $error("pin not inverted crystal");
    property p_tick_block;
        settled && (tck == 2'h3 || (tck == 2'h1 && osc != 2'h2) || (tck == 2'h2 && osc != 2'h3))
            |-> !tick_reference_clock_o;
    endproperty
    a_tick_block: assert property (p_tick_block) else $error("blocked tick source ran");
    property p_bus_half; bus_clock_o && seen_reg |-> gap_reg == 2'h2; endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus not half rate");
    c_vco: cover property (vco_clock_o);
    c_xtal: cover property (settled && osc == 2'h3 && osc_output_pin_o);
    c_stop: cover property (stop_mode_i && cfg_reg[0]);
endmodule
bind csp_clock_select csp_clock_select_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .stop_mode_i(stop_mode_i), .xtal_osc_level_i(xtal_osc_level_i),
    .internal_osc_clock_o(internal_osc_clock_o), .selected_osc_clock_o(selected_osc_clock_o),
    .tick_reference_clock_o(tick_reference_clock_o), .vco_clock_o(vco_clock_o),
    .clock_module_output_o(clock_module_output_o), .bus_clock_o(bus_clock_o),
    .osc_output_pin_o(osc_output_pin_o));

// ---- tb/test_csp_clock_select.sv ----
// Self-checking bench for the clock source select block.
`timescale 1ns/1ps
`include "csp_consts.vh"
module test_csp_clock_select;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, q, seed = 96796;
    logic        rc_osc_level_i = 1'b0, xtal_osc_level_i = 1'b0, stop_mode_i = 1'b0;
    logic        rc_q = 1'b0, xt_q = 1'b0, pin_q = 1'b0, meas = 1'b0;
    wire  [31:0] dat_o;
    wire         ack_o, internal_osc_clock, sclk, tclk, vclk, pclk, cmp, cmo, bclk, pin;
    integer      cnt [0:11];
    integer      error_cnt = 0, comparisons = 0, cycles = 0, ph = 0, i, o, t, e;
    integer      pp [0:2] = '{1, 3, 0};
    integer      nn [0:2] = '{3, 1, 4095};
    integer      rr [0:2] = '{2, 1, 4095};
    csp_clock_select DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rc_osc_level_i(rc_osc_level_i), .xtal_osc_level_i(xtal_osc_level_i),
        .stop_mode_i(stop_mode_i), .internal_osc_clock_o(internal_osc_clock), .selected_osc_clock_o(sclk),
        .tick_reference_clock_o(tclk), .vco_clock_o(vclk), .pll_divided_clock_o(pclk),
        .pll_compare_o(cmp), .clock_module_output_o(cmo), .bus_clock_o(bclk),
        .osc_output_pin_o(pin));
    always #12.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    // Oscillator waveforms, pulse counters and the hang limit.
    always @(posedge clk_i) begin
        ph <= ph + 1;
        rc_osc_level_i <= (ph % 6) < 3;
        xtal_osc_level_i <= (ph % 8) < 4;
        rc_q <= rc_osc_level_i;
        xt_q <= xtal_osc_level_i;
        pin_q <= pin;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up;
        end
        if (meas) begin
            cnt[0] += internal_osc_clock;
            cnt[1] += sclk;
            cnt[2] += tclk;
            cnt[3] += vclk;
            cnt[4] += pclk;
            cnt[5] += cmp;
            cnt[6] += cmo;
            cnt[7] += bclk;
            cnt[8] += pin != pin_q;
            cnt[9] += rc_osc_level_i && !rc_q;
            cnt[10] += xtal_osc_level_i && !xt_q;
            cnt[11] += pin !== !xt_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input logic [31:0] got, input integer exp, input integer tol);
        comparisons++;
        if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
            error_cnt++;
            $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= s;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task rd(input logic [5:0] idx, input integer exp);
        wb(1'b0, idx, 32'h0, 4'hF);
        chk(q, exp, 0);
    endtask
    task cfg_wr(input integer o2, input integer t2, input integer d2);
        wb(1'b1, `CSP_IDX_SYSTEM_CONFIG_TWO, (o2 << `CSP_CFG_OSC_LO) | (t2 << `CSP_CFG_TICK_LO) | d2, 4'hF);
        repeat (20) @(posedge clk_i);
    endtask
    task meas_run(input integer n);
        for (int k = 0; k < 12; k++) cnt[k] = 0;
        meas <= 1'b1;
        repeat (n) @(posedge clk_i);
        meas <= 1'b0;
    endtask
    task wrap_up;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`CSP_IDX_SYSTEM_CONFIG_TWO, `CSP_RST_SYSTEM_CONFIG_TWO);
        rd(`CSP_IDX_PLL_CTRL, 0);
        rd(`CSP_IDX_PLL_MULT, 1);
        rd(`CSP_IDX_PLL_REFDIV, 1);
        wb(1'b1, 6'h3F, 32'hFF, 4'hF);
        rd(6'h3F, 0);
        wb(1'b1, `CSP_IDX_PLL_MULT, 32'h0, 4'h3);
        rd(`CSP_IDX_PLL_MULT, 1);
        for (i = 0; i < 3; i++) begin
            seed = xs(seed);
            wb(1'b1, `CSP_IDX_SYSTEM_CONFIG_TWO, seed[7:0], 4'hF);
            rd(`CSP_IDX_SYSTEM_CONFIG_TWO, seed[7:0]);
        end
        wb(1'b1, `CSP_IDX_SYSTEM_CONFIG_TWO, ~seed, 4'hE);
        rd(`CSP_IDX_SYSTEM_CONFIG_TWO, seed[7:0]);
        for (o = 0; o < 4; o++) begin
            for (t = 0; t < 4; t++) begin
                cfg_wr(o, t, 0);
                meas_run(240);
                e = o == 1 ? 24 : o == 2 ? cnt[9] : o == 3 ? cnt[10] : 0;
                chk(cnt[0], 24, 1);
                chk(cnt[1], e, 1);
                chk(cnt[2], t == 0 ? 24 : t == 1 && o == 2 ? cnt[9] : t == 2 && o == 3 ? cnt[10] : 0, 1);
                chk(cnt[6], e, 1);
                chk(cnt[7], e / 2, 1);
                chk(o == 3 ? cnt[11] : cnt[8], o == 3 ? 0 : e, o != 3);
            end
        end
        cfg_wr(1, 0, 1);
        stop_mode_i <= 1'b1;
        @(posedge clk_i);
        meas_run(100);
        chk(cnt[0], 0, 0);
        rd(`CSP_IDX_STATUS, 16 + `CSP_OSC_INT);
        cfg_wr(1, 0, 0);
        meas_run(100);
        chk(cnt[0], 10, 1);
        stop_mode_i <= 1'b0;
        for (i = 0; i < 3; i++) begin
            wb(1'b1, `CSP_IDX_PLL_MULT, nn[i], 4'h3);
            wb(1'b1, `CSP_IDX_PLL_REFDIV, rr[i], 4'h3);
            wb(1'b1, `CSP_IDX_PLL_CTRL, pp[i] + 4, 4'hF);
            repeat (40) @(posedge clk_i);
            meas_run(400);
            e = 40 * nn[i] * (1 << pp[i]) / rr[i];
            chk(cnt[3], e, 2);
            chk(cnt[4], e >> pp[i], 2);
            chk(cnt[5], 40 / rr[i], 1);
            chk(cnt[6], e >> (pp[i] + 1), 2);
            chk(cnt[7], e >> (pp[i] + 2), 2);
        end
        wrap_up;
    end
endmodule
